/* File: pkg/isa_claim_pkg.sv */
// Shared constants, field positions and carrier types for the ISA claim and slot control block
package isa_claim_pkg;

  // ----------------
  // Configuration register offsets
  // ----------------
  localparam logic [7:0] FEATURE_CONTROL_OFS = 8'h52;
  localparam logic [7:0] SLOT_ENABLE_CTRL_A_OFS = 8'h5C;
  localparam logic [7:0] SLOT_ENABLE_CTRL_B_OFS = 8'h5D;

  // ----------------
  // Reset values
  // ----------------
  localparam logic [7:0] FEATURE_CONTROL_RST = 8'h20;
  localparam logic [7:0] SLOT_ENABLE_CTRL_A_RST = 8'h00;
  localparam logic [7:0] SLOT_ENABLE_CTRL_B_RST = 8'h00;
  localparam logic [7:0] SLOT_ENABLE_CTRL_B_MASK = 8'h0F;

  // ----------------
  // Feature control bit positions
  // ----------------
  localparam int FC_STROBE_ROLE = 7;
  localparam int FC_SLOT_GATE_EN = 6;
  localparam int FC_IDE_EN = 5;
  localparam int FC_IDE_PIN_SEL = 4;
  localparam int FC_HOT_HALT_EN = 3;
  localparam int FC_FLASH_WR_EN = 2;
  localparam int FC_IRQ8_HIGH = 1;
  localparam int FC_DMA_DISTRIB = 0;

  // ----------------
  // Slot field layout: option bit above a 3-bit range code
  // ----------------
  localparam int SLOT_CODE_LSB_LO = 0;
  localparam int SLOT_OPT_BIT_LO = 3;
  localparam int SLOT_CODE_LSB_HI = 4;
  localparam int SLOT_OPT_BIT_HI = 7;
  localparam logic [2:0] SLOT_CODE_ALL = 3'h0;
  localparam logic [8:0] SLOT_EXCL_TOP = 9'h07F;

  // ----------------
  // ISA decode limits and claim data
  // ----------------
  localparam logic [31:0] ISA_MEM_LIMIT = 32'h0100_0000;
  localparam logic [31:0] ISA_IO_LIMIT = 32'h0001_0000;
  localparam logic [31:0] ISA_LOW_MEG = 32'h0010_0000;
  localparam logic [7:0] FLOAT_BYTE = 8'hFF;

  // ----------------
  // Control latch pattern and strobe timing in sys_clk cycles
  // ----------------
  localparam logic [15:0] LATCH_RESET_PATTERN = 16'h001E;
  localparam logic [3:0] LATCH_SETUP_CYC = 4'h2;
  localparam logic [3:0] LATCH_PULSE_CYC = 4'h3;
  localparam logic [3:0] LATCH_HOLD_CYC = 4'h2;

  // ----------------
  // Carrier types
  // ----------------
  typedef struct packed {
    logic is_io;
    logic is_write;
    logic [31:0] addr;
  } pci_req_t;

  typedef struct packed {
    logic m16_n;
    logic io16_n;
    logic nows_n;
    logic iochrdy;
    logic done;
    logic [7:0] rdata;
  } isa_resp_t;

  typedef struct packed {
    logic [2:0] code;
    logic opt;
  } slot_cfg_t;

endpackage

/* File: design/slot_addr_gate.sv */
// Per-slot address-enable window decode for three ISA slots
`timescale 1ns/1ns
`default_nettype none
module slot_addr_gate
  import isa_claim_pkg::*;
(
  input wire logic [15:0] io_addr,
  input wire logic io_cycle,
  input wire logic dma_cycle,
  input wire logic gate_en,
  input wire isa_claim_pkg::slot_cfg_t [2:0] slot_cfg,
  output logic [2:0] next_gate
);

  // ----------------
  // Window decode shared by all slots
  // ----------------
  // True when the slot may see this I/O address (gate driven low)
  function automatic logic in_window(input logic [15:0] a, input slot_cfg_t c);
    logic hit;
    hit = (c.code == SLOT_CODE_ALL) || (a[15:12] == {1'b0, c.code});
    if (c.opt && (a[11:3] <= SLOT_EXCL_TOP)) begin
      hit = 1'b0;
    end
    return hit;
  endfunction

  // ----------------
  // Gate level per slot
  // ----------------
  // DMA drives the gates high as normal; memory cycles stay low as normal
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (dma_cycle) begin
        next_gate[i] = 1'b1;
      end else if (!gate_en || !io_cycle) begin
        next_gate[i] = 1'b0;
      end else begin
        next_gate[i] = !in_window(io_addr, slot_cfg[i]);
      end
    end
  end

endmodule // slot_addr_gate
`default_nettype wire

/* File: design/ctl_latch_seq.sv */
// Sequencer that presents a control pattern on SA and pulses the latch strobe
`timescale 1ns/1ns
`default_nettype none
module ctl_latch_seq
  import isa_claim_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [15:0] pattern,
  output logic busy,
  output logic strobe,
  output logic [15:0] sa_drive
);

  typedef enum logic [1:0] {IDLE, SETUP, PULSE, HOLD} seq_state_t;

  seq_state_t state; // Sequencer phase
  logic [3:0] cnt; // Cycles left in phase

  // ----------------
  // Phase sequencing
  // ----------------
  // Reset leaves strobe high with the reset pattern so the latch is transparent
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= IDLE;
      cnt <= 4'h0;
      strobe <= 1'b1;
      sa_drive <= LATCH_RESET_PATTERN;
    end else begin
      case (state)
        IDLE: begin
          strobe <= 1'b0;
          if (start) begin
            sa_drive <= pattern;
            cnt <= LATCH_SETUP_CYC;
            state <= SETUP;
          end
        end
        SETUP: begin
          // Pattern settles before the latch opens
          if (cnt == 4'h1) begin
            strobe <= 1'b1;
            cnt <= LATCH_PULSE_CYC;
            state <= PULSE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        PULSE: begin
          if (cnt == 4'h1) begin
            strobe <= 1'b0;
            cnt <= LATCH_HOLD_CYC;
            state <= HOLD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        HOLD: begin
          // Pattern held past the closing edge of the strobe
          if (cnt == 4'h1) begin
            state <= IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: begin
          state <= IDLE;
        end
      endcase
    end
  end

  assign busy = (state != IDLE);

endmodule // ctl_latch_seq
`default_nettype wire

/* File: design/isa_claim_and_slot_control.sv */
// Top: ISA claim decision, feature control, latch strobe pin and per-slot gates
//
// Behaviour
// - Decode in-range cycles and run them on ISA
// - Claim early on 16-bit, zero-wait or not-ready
// - Unclaimed 8-bit write completes, then target abort
// - Unclaimed 8-bit read waits for returned data
// - Dual pin is latch strobe at initialisation
// - Reset drives fixed pattern onto address lines
// - Feature bit 7 selects reset or strobe role
// - Latched bit0 reserved, 1-4 slot resets, rest user
// - Each latched output set by software pattern
// - Extended mode gates stay high outside window
// - Range code: 000 all, else 4K window
// - Option bit excludes x000-x3F8 in window
// - Slot fields packed in two slot registers
// - Slot gates 2 and 3 replace request pair 1
// - Feature bit 6 enables gates, needs strap
// - Bits 5 and 4 control drive function, pins
// - Bit 3 hot halt; bit 2 flash/write block
// - Bit 1 irq8 level; bit 0 DMA mapping
// - Hot insertion halts ISA until host clears
// - Extended mode strapped on drive select pin
`timescale 1ns/1ns
`default_nettype none
module isa_claim_and_slot_control
  import isa_claim_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic pci_req_valid,
  input wire isa_claim_pkg::pci_req_t pci_req,
  output logic pci_claim,
  output logic pci_target_abort,
  output logic isa_start,
  output isa_claim_pkg::pci_req_t isa_cmd,
  input wire isa_claim_pkg::isa_resp_t isa_resp,
  input wire logic dma_cycle,
  output logic isa_halt,
  input wire logic hot_insert_n,
  input wire logic hot_clear,
  input wire logic isa_reset_req,
  input wire logic latch_update,
  input wire logic [15:0] latch_pattern,
  output logic reset_or_strobe_pin,
  output logic [15:0] sa_out,
  output logic sa_oe,
  input wire logic drive_cs_one_n,
  input wire logic ack_encode_strap,
  output logic [2:0] slot_addr_gates,
  output logic extended_mode,
  output logic ide_function,
  output logic ide_buffer_pins,
  output logic mem_write_block,
  input wire logic irq8_input,
  output logic irq8_active,
  output logic dma_distributed
);

  import isa_claim_pkg::*;

  // ----------------
  // Declarations
  // ----------------
  typedef enum logic [1:0] {C_IDLE, C_RUN, C_DONE} claim_state_t;

  logic [7:0] feature_control; // Feature control register
  logic [7:0] slot_enable_ctrl_a; // Slots 1 and 2 fields
  logic [7:0] slot_enable_ctrl_b; // Slot 3 field, upper nibble reserved
  claim_state_t cstate; // Claim decision state
  logic claimed; // An early response was seen this cycle
  logic strap_taken; // Straps captured once after reset
  logic ack_strap; // Captured acknowledge-encode strap
  logic hot_pending; // Hot insertion event awaiting host clear
  logic seq_busy; // Latch sequencer running
  logic seq_strobe; // Strobe from sequencer
  logic [15:0] seq_sa; // Pattern from sequencer
  logic seq_start; // Start request to sequencer
  logic gate_en; // Individual gates permitted
  logic early_resp; // Any card response event
  logic [2:0] next_gates; // Combinational gate levels
  slot_cfg_t [2:0] slot_cfg; // Unpacked slot fields

  // Memory range: first 16MB; I/O range: first 64KB
  function automatic logic in_isa_range(input pci_req_t r);
    return r.is_io ? (r.addr < ISA_IO_LIMIT) : (r.addr < ISA_MEM_LIMIT);
  endfunction

  // ----------------
  // Configuration register writes
  // ----------------
  // Reserved bits of the second slot register never store
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      feature_control <= FEATURE_CONTROL_RST;
      slot_enable_ctrl_a <= SLOT_ENABLE_CTRL_A_RST;
      slot_enable_ctrl_b <= SLOT_ENABLE_CTRL_B_RST;
    end else if (cfg_wr) begin
      case (cfg_addr)
        FEATURE_CONTROL_OFS: feature_control <= cfg_wdata;
        SLOT_ENABLE_CTRL_A_OFS: slot_enable_ctrl_a <= cfg_wdata;
        SLOT_ENABLE_CTRL_B_OFS: slot_enable_ctrl_b <= cfg_wdata & SLOT_ENABLE_CTRL_B_MASK;
        default: begin
          // Unmapped offsets are ignored
        end
      endcase
    end
  end

  // ----------------
  // Configuration register reads
  // ----------------
  // Data appears the cycle after the read; unmapped offsets read zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      case (cfg_addr)
        FEATURE_CONTROL_OFS: cfg_rdata <= feature_control;
        SLOT_ENABLE_CTRL_A_OFS: cfg_rdata <= slot_enable_ctrl_a;
        SLOT_ENABLE_CTRL_B_OFS: cfg_rdata <= slot_enable_ctrl_b;
        default: cfg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------
  // Strap capture
  // ----------------
  // Straps are sampled by the first clock after reset release, never by the reset itself
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken <= 1'b0;
      extended_mode <= 1'b0;
      ack_strap <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      extended_mode <= drive_cs_one_n;
      ack_strap <= ack_encode_strap;
    end
  end

  // ----------------
  // Feature-driven outputs
  // ----------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ide_function <= 1'b1;
      ide_buffer_pins <= 1'b0;
      mem_write_block <= 1'b0;
      irq8_active <= 1'b0;
      dma_distributed <= 1'b0;
    end else begin
      ide_function <= feature_control[FC_IDE_EN];
      ide_buffer_pins <= feature_control[FC_IDE_PIN_SEL];
      // Memory writes below 1MB are blocked while flash writes are off
      mem_write_block <= !feature_control[FC_FLASH_WR_EN] && isa_start && !isa_cmd.is_io
                         && isa_cmd.is_write && (isa_cmd.addr < ISA_LOW_MEG);
      irq8_active <= feature_control[FC_IRQ8_HIGH] ? irq8_input : !irq8_input;
      dma_distributed <= feature_control[FC_DMA_DISTRIB];
    end
  end

  // ----------------
  // Hot insertion halt
  // ----------------
  // A new insertion in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hot_pending <= 1'b0;
    end else if (feature_control[FC_HOT_HALT_EN] && !hot_insert_n) begin
      hot_pending <= 1'b1;
    end else if (hot_clear) begin
      hot_pending <= 1'b0;
    end
  end

  // Halt reaches the bus the cycle after the event
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      isa_halt <= 1'b0;
    end else begin
      isa_halt <= hot_pending || (feature_control[FC_HOT_HALT_EN] && !hot_insert_n);
    end
  end

  // ----------------
  // Claim decision
  // ----------------
  assign early_resp = !isa_resp.m16_n || !isa_resp.io16_n || !isa_resp.nows_n || !isa_resp.iochrdy;

  // One ISA cycle at a time; a halted bus or a running strobe holds new cycles off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cstate <= C_IDLE;
      claimed <= 1'b0;
      isa_start <= 1'b0;
      isa_cmd <= '0;
      pci_claim <= 1'b0;
      pci_target_abort <= 1'b0;
    end else begin
      isa_start <= 1'b0;
      pci_claim <= 1'b0;
      pci_target_abort <= 1'b0;
      case (cstate)
        C_IDLE: begin
          if (pci_req_valid && in_isa_range(pci_req) && !isa_halt && !hot_pending && !seq_busy) begin
            isa_start <= 1'b1;
            isa_cmd <= pci_req;
            claimed <= 1'b0;
            cstate <= C_RUN;
          end
        end
        C_RUN: begin
          if (!claimed && early_resp) begin
            // Claim without waiting for the ISA cycle to end
            pci_claim <= 1'b1;
            claimed <= 1'b1;
          end
          if (isa_resp.done) begin
            if (!claimed && !early_resp) begin
              if (isa_cmd.is_write) begin
                pci_target_abort <= 1'b1;
              end else if (isa_resp.rdata != FLOAT_BYTE) begin
                pci_claim <= 1'b1;
              end else begin
                // Floating bus; the host reruns locally and sees the same byte
                pci_target_abort <= 1'b1;
              end
            end
            cstate <= C_DONE;
          end
        end
        C_DONE: begin
          // One turnaround cycle; a strobe cannot start here, only in C_IDLE with no request pending
          cstate <= C_IDLE;
        end
        default: begin
          cstate <= C_IDLE;
        end
      endcase
    end
  end

  // ----------------
  // Control latch strobe
  // ----------------
  // Strobe only starts between ISA cycles and only in strobe role
  assign seq_start = latch_update && feature_control[FC_STROBE_ROLE] && (cstate == C_IDLE)
                     && !pci_req_valid;

  ctl_latch_seq u_latch (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(seq_start),
    .pattern(latch_pattern),
    .busy(seq_busy),
    .strobe(seq_strobe),
    .sa_drive(seq_sa)
  );

  // Pin role: plain ISA reset drive or latch strobe, never both
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_or_strobe_pin <= 1'b1;
      sa_out <= LATCH_RESET_PATTERN;
      sa_oe <= 1'b1;
    end else begin
      if (feature_control[FC_STROBE_ROLE]) begin
        reset_or_strobe_pin <= seq_strobe;
      end else begin
        reset_or_strobe_pin <= isa_reset_req;
      end
      // Address lines carry the pattern while the sequencer owns them
      sa_out <= seq_busy ? seq_sa : isa_cmd.addr[15:0];
      sa_oe <= seq_busy || (cstate != C_IDLE);
    end
  end

  // ----------------
  // Per-slot address gates
  // ----------------
  // Gates need extended mode, the acknowledge strap and the enable bit, in either pin role
  assign gate_en = extended_mode && ack_strap && feature_control[FC_SLOT_GATE_EN];
  assign slot_cfg[0] = '{code: slot_enable_ctrl_a[SLOT_CODE_LSB_LO +: 3],
                         opt: slot_enable_ctrl_a[SLOT_OPT_BIT_LO]};
  assign slot_cfg[1] = '{code: slot_enable_ctrl_a[SLOT_CODE_LSB_HI +: 3],
                         opt: slot_enable_ctrl_a[SLOT_OPT_BIT_HI]};
  assign slot_cfg[2] = '{code: slot_enable_ctrl_b[SLOT_CODE_LSB_LO +: 3],
                         opt: slot_enable_ctrl_b[SLOT_OPT_BIT_LO]};

  slot_addr_gate u_gate (
    .io_addr(isa_cmd.addr[15:0]),
    .io_cycle(isa_cmd.is_io && (cstate != C_IDLE)),
    .dma_cycle(dma_cycle),
    .gate_en(gate_en),
    .slot_cfg(slot_cfg),
    .next_gate(next_gates)
  );

  // Bit 0 is the original gate pin; bits 1 and 2 take the spare request pair pins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_addr_gates <= 3'h0;
    end else begin
      slot_addr_gates <= next_gates;
    end
  end

endmodule // isa_claim_and_slot_control
`default_nettype wire

/* File: dv/isa_card_model.sv */
// Behavioural ISA slot card answering the cycles that the bridge starts
`timescale 1ns/1ns
`default_nettype none
module isa_card_model
  import isa_claim_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic isa_start,
  input wire logic [2:0] mode,
  input wire logic [7:0] dat,
  output isa_claim_pkg::isa_resp_t resp
);
  // Cycle position, 1 to 4 in a cycle, then runs on through 7 and parks at zero
  logic [2:0] cnt;
  logic act;
  // Restart on every new cycle; the count runs out and parks at zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 3'h0;
    end else if (isa_start) begin
      cnt <= 3'h1;
    end else if (cnt != 3'h0) begin
      cnt <= cnt + 3'h1;
    end
  end
  // Early signal held from the second cycle up to the end of the cycle
  assign act = (cnt >= 3'h2) && (cnt <= 3'h4);
  assign resp.m16_n = !(act && mode == 3'h1);
  assign resp.io16_n = !(act && mode == 3'h2);
  assign resp.nows_n = !(act && mode == 3'h3);
  assign resp.iochrdy = !(act && mode == 3'h4);
  assign resp.done = (cnt == 3'h4);
  // Data bus is pulled up, so a released bus reads all ones
  assign resp.rdata = resp.done ? dat : 8'hFF;
endmodule // isa_card_model
`default_nettype wire

/* File: dv/isa_claim_checker.sv */
// Concurrent checks on claim decision, latch strobe and hot halt
`timescale 1ns/1ns
`default_nettype none
module isa_claim_checker
  import isa_claim_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pci_claim,
  input wire logic pci_target_abort,
  input wire logic isa_start,
  input wire isa_claim_pkg::pci_req_t isa_cmd,
  input wire isa_claim_pkg::isa_resp_t isa_resp,
  input wire logic isa_halt,
  input wire logic hot_insert_n,
  input wire logic hot_clear,
  input wire logic reset_or_strobe_pin,
  input wire logic [15:0] sa_out,
  input wire logic sa_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------
  // Helper state: cycle running and early response already seen
  // ----------------
  logic run;
  logic seen;
  wire early = !isa_resp.m16_n || !isa_resp.io16_n || !isa_resp.nows_n || !isa_resp.iochrdy;
  wire fresh = run && !seen && !early;
  wire at_end = fresh && isa_resp.done;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run <= 1'b0;
    end else if (isa_start) begin
      run <= 1'b1;
    end else if (isa_resp.done) begin
      run <= 1'b0;
    end
  end
  // Remembers an early claim so the end of cycle gives no second answer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen <= 1'b0;
    end else if (isa_start) begin
      seen <= 1'b0;
    end else if (run && early) begin
      seen <= 1'b1;
    end
  end
  sequence strobe_high_s;
    (reset_or_strobe_pin && sa_oe && $stable(sa_out)) [*3];
  endsequence
  sequence strobe_hold_s;
    !reset_or_strobe_pin && sa_oe && $stable(sa_out);
  endsequence
  one_answer_a: assert property (!(pci_claim && pci_target_abort))
    else $error("claim and abort together");
  early_claim_a: assert property (run && !seen && early |=> pci_claim)
    else $error("early response not claimed");
  early_no_abort_a: assert property (seen && isa_resp.done |=> !pci_target_abort)
    else $error("abort after early claim");
  write_abort_a: assert property (at_end && isa_cmd.is_write |=> pci_target_abort)
    else $error("silent write not aborted");
  read_wait_a: assert property (fresh && !isa_resp.done |=> !pci_claim && !pci_target_abort)
    else $error("answer before read data");
  read_claim_a: assert property (at_end && !isa_cmd.is_write && isa_resp.rdata != FLOAT_BYTE |=> pci_claim)
    else $error("driven read data not claimed");
  read_float_a: assert property (at_end && !isa_cmd.is_write && isa_resp.rdata == FLOAT_BYTE |=> pci_target_abort)
    else $error("floating read not aborted");
  strobe_frame_a: assert property ($rose(reset_or_strobe_pin) && sa_oe |-> strobe_high_s ##1 strobe_hold_s)
    else $error("strobe without stable pattern");
  halt_hold_a: assert property (isa_halt && !$past(hot_clear) && !(hot_clear && hot_insert_n) |=> isa_halt)
    else $error("halt dropped early");
  halt_block_a: assert property (isa_halt |=> !isa_start)
    else $error("cycle started while halted");
endmodule // isa_claim_checker
bind isa_claim_and_slot_control isa_claim_checker u_chk (
  .sys_clk, .rst_n, .pci_claim, .pci_target_abort, .isa_start, .isa_cmd, .isa_resp,
  .isa_halt, .hot_insert_n, .hot_clear, .reset_or_strobe_pin, .sa_out, .sa_oe
);
`default_nettype wire

/* File: dv/tb_isa_claim_and_slot_control.sv */
// Self-checking bench for the ISA claim and slot control block
`timescale 1ns/1ns
`default_nettype none
module tb_isa_claim_and_slot_control;
  import isa_claim_pkg::*;
  // ----------------
  // Stimulus, observed outputs and scoreboard
  // ----------------
  logic sys_clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata, dat = 8'h00;
  logic pci_req_valid = 1'b0, hot_insert_n = 1'b1, hot_clear = 1'b0, isa_reset_req = 1'b0;
  logic latch_update = 1'b0, irq8_input = 1'b1, dma_cycle = 1'b0;
  logic [15:0] latch_pattern = 16'h0000, sa_out;
  logic [2:0] mode = 3'h0, slot_addr_gates, gts;
  pci_req_t pci_req = '0, isa_cmd;
  isa_resp_t isa_resp;
  logic pci_claim, pci_target_abort, isa_start, isa_halt, reset_or_strobe_pin, sa_oe;
  logic extended_mode, ide_function, ide_buffer_pins, mem_write_block, irq8_active, dma_distributed;
  logic st, cl, ab, mwb;
  int error_cnt = 0, checks = 0;
  // Claim cases: write, card mode, read data, claim expected
  localparam logic [12:0] CASES [7] = '{13'h03FF, 13'h1401, 13'h07FF, 13'h1801, 13'h10B4, 13'h0025, 13'h01FE};
  always #4 sys_clk = ~sys_clk;
  // Straps select extended mode with the encoded acknowledge lines
  isa_claim_and_slot_control uut (.sys_clk, .rst_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata,
    .pci_req_valid, .pci_req, .pci_claim, .pci_target_abort, .isa_start, .isa_cmd, .isa_resp,
    .dma_cycle, .isa_halt, .hot_insert_n, .hot_clear, .isa_reset_req, .latch_update, .latch_pattern,
    .reset_or_strobe_pin, .sa_out, .sa_oe, .drive_cs_one_n(1'b1), .ack_encode_strap(1'b1), .slot_addr_gates,
    .extended_mode, .ide_function, .ide_buffer_pins, .mem_write_block, .irq8_input, .irq8_active,
    .dma_distributed);
  isa_card_model card (.sys_clk, .rst_n, .isa_start, .mode, .dat, .resp(isa_resp));
  // Inputs always move 1 ns after the rising edge
  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (!ok) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    tick();
    cfg_wr = 1'b0;
    tick();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cfg_addr = a;
    cfg_rd = 1'b1;
    tick();
    cfg_rd = 1'b0;
    chk(cfg_rdata === e, "register read");
    tick();
  endtask
  // Request held until taken or for at most 20 cycles; gates and write block sampled one cycle in
  task automatic cyc(input logic io, w, input logic [31:0] a, input logic [2:0] m, input logic [7:0] d);
    int i;
    mode = m;
    dat = d;
    pci_req = '{io, w, a};
    pci_req_valid = 1'b1;
    for (i = 0; i < 20 && isa_start !== 1'b1; i++) tick();
    st = isa_start;
    pci_req_valid = 1'b0;
    tick();
    gts = slot_addr_gates;
    mwb = mem_write_block;
    cl = 1'b0;
    ab = 1'b0;
    for (i = 0; i < 12; i++) begin
      tick();
      cl |= pci_claim;
      ab |= pci_target_abort;
    end
  endtask
  task automatic t_regs();
    rd(FEATURE_CONTROL_OFS, 8'h20);
    rd(SLOT_ENABLE_CTRL_A_OFS, 8'h00);
    rd(8'h53, 8'h00);
    wr(SLOT_ENABLE_CTRL_B_OFS, 8'hFF);
    rd(SLOT_ENABLE_CTRL_B_OFS, 8'h0F);
    $display("regs done");
  endtask
  task automatic t_claim();
    logic [12:0] c;
    for (int k = 0; k < 7; k++) begin
      c = CASES[k];
      cyc(1'b1, c[12], 32'h0000_0300, c[11:9], c[8:1]);
      chk(st === 1'b1 && cl === c[0] && ab === !c[0], "claim decision");
    end
    chk(isa_cmd === pci_req_t'{1'b1, 1'b0, 32'h0000_0300}, "forwarded command");
    cyc(1'b1, 1'b0, 32'h0001_0000, 3'h1, 8'h00);
    chk(st === 1'b0 && cl === 1'b0 && ab === 1'b0, "out of range taken");
    $display("claim done");
  endtask
  task automatic t_feat();
    wr(FEATURE_CONTROL_OFS, 8'h13);
    cyc(1'b0, 1'b1, 32'h000C_0000, 3'h1, 8'h00);
    chk(ide_function === 1'b0 && ide_buffer_pins === 1'b1, "drive pins");
    chk(irq8_active === 1'b1 && dma_distributed === 1'b1 && mwb === 1'b1, "feature bits");
    wr(FEATURE_CONTROL_OFS, 8'h15);
    cyc(1'b0, 1'b1, 32'h000C_0000, 3'h1, 8'h00);
    chk(irq8_active === 1'b0 && mwb === 1'b0, "feature bits");
    $display("feature done");
  endtask
  task automatic t_gates();
    wr(FEATURE_CONTROL_OFS, 8'h60);
    wr(SLOT_ENABLE_CTRL_A_OFS, 8'h0B);
    wr(SLOT_ENABLE_CTRL_B_OFS, 8'h05);
    chk(extended_mode === 1'b1, "strap");
    cyc(1'b1, 1'b0, 32'h0000_3500, 3'h1, 8'h00);
    chk(gts === 3'b100, "window gates");
    cyc(1'b1, 1'b0, 32'h0000_3100, 3'h1, 8'h00);
    chk(gts === 3'b101, "excluded gates");
    cyc(1'b1, 1'b0, 32'h0000_5008, 3'h1, 8'h00);
    chk(gts === 3'b001, "slot three gates");
    cyc(1'b0, 1'b0, 32'h0000_3500, 3'h1, 8'h00);
    chk(gts === 3'b000, "memory gates");
    dma_cycle = 1'b1;
    cyc(1'b1, 1'b0, 32'h0000_3500, 3'h1, 8'h00);
    dma_cycle = 1'b0;
    chk(gts === 3'b111, "dma gates");
    $display("gates done");
  endtask
  task automatic t_strobe();
    int i;
    isa_reset_req = 1'b1;
    tick(2);
    chk(reset_or_strobe_pin === 1'b1, "reset role");
    isa_reset_req = 1'b0;
    tick(2);
    chk(reset_or_strobe_pin === 1'b0, "reset role");
    wr(FEATURE_CONTROL_OFS, 8'h80);
    latch_pattern = 16'h0A5A;
    latch_update = 1'b1;
    tick();
    latch_update = 1'b0;
    for (i = 0; i < 10 && reset_or_strobe_pin !== 1'b1; i++) tick();
    chk(reset_or_strobe_pin === 1'b1 && sa_out === 16'h0A5A && sa_oe === 1'b1, "latch");
    tick(8);
    chk(sa_oe === 1'b0, "bus release");
    $display("strobe done");
  endtask
  task automatic t_hot();
    wr(FEATURE_CONTROL_OFS, 8'h08);
    hot_insert_n = 1'b0;
    tick();
    hot_insert_n = 1'b1;
    cyc(1'b1, 1'b0, 32'h0000_0300, 3'h1, 8'h00);
    chk(isa_halt === 1'b1 && st === 1'b0, "halt");
    hot_clear = 1'b1;
    tick();
    hot_clear = 1'b0;
    cyc(1'b1, 1'b0, 32'h0000_0300, 3'h1, 8'h00);
    chk(isa_halt === 1'b0 && st === 1'b1 && cl === 1'b1, "resume");
    $display("hot done");
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    tick(3);
    chk(sa_out === LATCH_RESET_PATTERN && sa_oe === 1'b1 && reset_or_strobe_pin === 1'b1, "reset");
    tick(3);
    rst_n = 1'b1;
    tick(2);
    t_regs();
    t_claim();
    t_feat();
    t_gates();
    t_strobe();
    t_hot();
    end_sim();
  end
  // Whole run needs about 330 cycles
  initial begin
    #100000;
    error_cnt++;
    $display("[FAIL] %0t watchdog", $time);
    end_sim();
  end
endmodule // tb_isa_claim_and_slot_control
`default_nettype wire
